// ===== shared/serdes_regs_pkg.sv
// Constants for the serial-receive status, link reset and analogue control registers.
// Assumes an 8-bit register port with 12-bit byte addresses, decoded upstream.
package serdes_regs_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 8;
   localparam int LANES      = 16;
   localparam int LANE_IDX_W = 4;
   localparam int PHASE_W    = 8;
   localparam int PLL_MACROS = 4;
   localparam int ARRIVAL_W  = 8;

   // ==========================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] RECOVERY_FREEZE_ADDR    = 12'h238;
   localparam logic [ADDR_W-1:0] RECOVERED_PHASE_ADDR    = 12'h239;
   localparam logic [ADDR_W-1:0] PLL_LOCK_STATUS_ADDR    = 12'h250;
   localparam logic [ADDR_W-1:0] LINK_DIGITAL_RESET_ADDR = 12'h253;
   localparam logic [ADDR_W-1:0] EXT_REFERENCE_ADDR      = 12'h2B0;
   localparam logic [ADDR_W-1:0] CURRENT_DOUBLER_ADDR    = 12'h2B1;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_BIT       = 0;
   localparam int LOCK_LIVE_LSB  = 4;
   localparam int LOCK_LOST_LSB  = 0;
   localparam logic CTRL_RESET   = 1'b0;
   localparam logic [PLL_MACROS-1:0] LOCK_LOST_RESET = 4'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

endpackage

// ===== hw/lane_arrival_store.sv
// Small memory of per-lane arrival values, written all lanes at once.
// Assumes write and read requests on sys_clk; read data appear one cycle later.
`timescale 1ns/1ns
module lane_arrival_store (
   input  wire logic                                         sys_clk,
   input  wire logic                                         rst,
   input  wire logic                                         ce,
   input  wire logic                                         wrEn,
   input  wire logic [serdes_regs_pkg::LANES-1:0][serdes_regs_pkg::ARRIVAL_W-1:0] wrData,
   input  wire logic [serdes_regs_pkg::LANE_IDX_W-1:0]       rdIdx,
   output logic      [serdes_regs_pkg::ARRIVAL_W-1:0]        rdData
);

   typedef struct packed {
      logic [serdes_regs_pkg::LANES-1:0][serdes_regs_pkg::ARRIVAL_W-1:0] mem;
      logic [serdes_regs_pkg::ARRIVAL_W-1:0]                            rd;
   } store_t;

   store_t state_q;
   store_t state_d;

   always_comb begin
      state_d = state_q;
      if (wrEn) begin
         state_d.mem = wrData;
      end
      // Registered read keeps the output straight from a flip-flop
      state_d.rd = state_q.mem[rdIdx];
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= '0;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   assign rdData = state_q.rd;

endmodule

// ===== hw/serdes_status_jesd_reset_regs.sv
// Register bank for recovered-clock phase, serial PLL lock, link reset and analogue controls.
// Assumes the serial control port delivers decoded byte reads and writes on sys_clk;
// phase and lock inputs come from the lane macros, asynchronous to sys_clk.
`timescale 1ns/1ns

// What this block does
// - A read of the phase register returns the phase of the lane chosen by lane_select.
// - That phase value is given in Gray code, not binary.
// - Bits 7-4 of the PLL status register show the live lock of the four PLL macros.
// - Bits 3-0 set whenever the matching PLL lock is low, one bit per four lanes.
// - Those lock-lost bits stay set until software writes a 1 to them; 0 does nothing.
// - While the link reset bit is 1 the digital link receiver is held in reset only.
// - Lane arrival values are captured only at the first buffer release after link reset or after power-up reset.
// - The external reference select bit switches to the external reference ball.
// - The current doubler bit drives the DAC output-current doubling control.
// - While the freeze bit is set the recovery loop stops and the phase is held.
module serdes_status_jesd_reset_regs (
   input  wire logic                                          sys_clk,
   input  wire logic                                          rst,
   input  wire logic                                          ce,
   input  wire logic                                          regWrite,
   input  wire logic                                          regRead,
   input  wire logic [serdes_regs_pkg::ADDR_W-1:0]            regAddr,
   input  wire logic [serdes_regs_pkg::DATA_W-1:0]            regWdata,
   output logic      [serdes_regs_pkg::DATA_W-1:0]            regRdata,
   output logic                                               regRvalid,
   input  wire logic [serdes_regs_pkg::LANE_IDX_W-1:0]        laneSelect,
   input  wire logic [serdes_regs_pkg::LANES-1:0][serdes_regs_pkg::PHASE_W-1:0] lanePhase,
   input  wire logic [serdes_regs_pkg::PLL_MACROS-1:0]        pllLockedLive,
   input  wire logic                                          elasticRelease,
   input  wire logic [serdes_regs_pkg::LANES-1:0][serdes_regs_pkg::ARRIVAL_W-1:0] laneArrivalIn,
   input  wire logic [serdes_regs_pkg::LANE_IDX_W-1:0]        laneArrivalIdx,
   output logic      [serdes_regs_pkg::ARRIVAL_W-1:0]         laneArrivalValues,
   output logic                                               recoveryFreeze,
   output logic                                               linkDigitalReset,
   output logic                                               extReferenceEnable,
   output logic                                               currentDoublerEnable
);

   // ==========================================================
   // State
   typedef logic [serdes_regs_pkg::LANES-1:0][serdes_regs_pkg::PHASE_W-1:0] phase_bank_t;

   typedef struct packed {
      logic                                      freeze;
      logic                                      linkRst;
      logic                                      ext_reference_ball;
      logic                                      curDbl;
      logic [serdes_regs_pkg::PLL_MACROS-1:0]    lockLost;
      logic [serdes_regs_pkg::PLL_MACROS-1:0]    lockMeta;
      logic [serdes_regs_pkg::PLL_MACROS-1:0]    lockSync;
      phase_bank_t                               phaseMeta;
      phase_bank_t                               phaseSync;
      phase_bank_t                               phaseHeld;
      logic                                      armed;
      logic [serdes_regs_pkg::DATA_W-1:0]        rdata;
      logic                                      rvalid;
   } regs_t;

   regs_t state_q;
   regs_t state_d;

   logic        captureNow;
   phase_bank_t phaseGray;

   // ==========================================================
   // Helpers
   function automatic logic [serdes_regs_pkg::PHASE_W-1:0] toGray(
      input logic [serdes_regs_pkg::PHASE_W-1:0] bin);
      toGray = bin ^ (bin >> 1);
   endfunction

   function automatic logic hits(input logic [serdes_regs_pkg::ADDR_W-1:0] a,
                                 input logic [serdes_regs_pkg::ADDR_W-1:0] reg_a);
      hits = (a == reg_a);
   endfunction

   // One live bit per control register; reserved bits always read zero
   function automatic logic [serdes_regs_pkg::DATA_W-1:0] ctrlByte(input logic b);
      ctrlByte                            = serdes_regs_pkg::READ_ZERO;
      ctrlByte[serdes_regs_pkg::CTRL_BIT] = b;
   endfunction

   // ==========================================================
   // Gray coding ahead of the crossing, so a sample caught mid-change is off by one step only
   genvar g;
   generate
      for (g = 0; g < serdes_regs_pkg::LANES; g = g + 1) begin : gGray
         assign phaseGray[g] = toGray(lanePhase[g]);
      end
   endgenerate

   // ==========================================================
   // Next state
   always_comb begin
      state_d = state_q;

      // Two-stage synchronisers; the first stage feeds only the second
      state_d.lockMeta  = pllLockedLive;
      state_d.lockSync  = state_q.lockMeta;
      state_d.phaseMeta = phaseGray;
      state_d.phaseSync = state_q.phaseMeta;

      // Held copy stops following while frozen, so a read sees a steady value
      if (!state_q.freeze) begin
         state_d.phaseHeld = state_q.phaseSync;
      end

      if (regWrite) begin
         if (hits(regAddr, serdes_regs_pkg::RECOVERY_FREEZE_ADDR)) begin
            state_d.freeze = regWdata[serdes_regs_pkg::CTRL_BIT];
         end
         if (hits(regAddr, serdes_regs_pkg::LINK_DIGITAL_RESET_ADDR)) begin
            state_d.linkRst = regWdata[serdes_regs_pkg::CTRL_BIT];
         end
         if (hits(regAddr, serdes_regs_pkg::EXT_REFERENCE_ADDR)) begin
            state_d.ext_reference_ball = regWdata[serdes_regs_pkg::CTRL_BIT];
         end
         if (hits(regAddr, serdes_regs_pkg::CURRENT_DOUBLER_ADDR)) begin
            state_d.curDbl = regWdata[serdes_regs_pkg::CTRL_BIT];
         end
         if (hits(regAddr, serdes_regs_pkg::PLL_LOCK_STATUS_ADDR)) begin
            state_d.lockLost = state_q.lockLost
                             & ~regWdata[serdes_regs_pkg::LOCK_LOST_LSB +:
                                         serdes_regs_pkg::PLL_MACROS];
         end
      end
      // Written bits 7-4 would land on read-only live status, so they are dropped
      // Setting after the clear means a loss in the clearing cycle survives
      state_d.lockLost = state_d.lockLost | ~state_q.lockSync;

      // Re-arm whenever the link logic is held; disarm after one capture
      if (state_q.linkRst) begin
         state_d.armed = 1'b1;
      end else if (captureNow) begin
         state_d.armed = 1'b0;
      end

      state_d.rvalid = regRead;
      state_d.rdata  = serdes_regs_pkg::READ_ZERO;
      if (regRead) begin
         case (regAddr)
            serdes_regs_pkg::RECOVERY_FREEZE_ADDR: begin
               state_d.rdata = ctrlByte(state_q.freeze);
            end
            serdes_regs_pkg::RECOVERED_PHASE_ADDR: begin
               // Lane select is applied in the read cycle; settle it a cycle ahead
               state_d.rdata = state_q.phaseHeld[laneSelect];
            end
            serdes_regs_pkg::PLL_LOCK_STATUS_ADDR: begin
               state_d.rdata[serdes_regs_pkg::LOCK_LIVE_LSB +: serdes_regs_pkg::PLL_MACROS] =
                  state_q.lockSync;
               state_d.rdata[serdes_regs_pkg::LOCK_LOST_LSB +: serdes_regs_pkg::PLL_MACROS] =
                  state_q.lockLost;
            end
            serdes_regs_pkg::LINK_DIGITAL_RESET_ADDR: begin
               state_d.rdata = ctrlByte(state_q.linkRst);
            end
            serdes_regs_pkg::EXT_REFERENCE_ADDR: begin
               state_d.rdata = ctrlByte(state_q.ext_reference_ball);
            end
            serdes_regs_pkg::CURRENT_DOUBLER_ADDR: begin
               state_d.rdata = ctrlByte(state_q.curDbl);
            end
            default: begin
               state_d.rdata = serdes_regs_pkg::READ_ZERO;
            end
         endcase
      end
   end

   // Release attempts while the link logic is held are not real releases
   assign captureNow = elasticRelease && state_q.armed && !state_q.linkRst;

   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // Sync flops start at unlocked, so every lock-lost bit sets just after
         // reset; software clears them once the macros report lock
         state_q          <= '0;
         state_q.freeze   <= serdes_regs_pkg::CTRL_RESET;
         state_q.linkRst  <= serdes_regs_pkg::CTRL_RESET;
         state_q.ext_reference_ball   <= serdes_regs_pkg::CTRL_RESET;
         state_q.curDbl   <= serdes_regs_pkg::CTRL_RESET;
         state_q.lockLost <= serdes_regs_pkg::LOCK_LOST_RESET;
         // Armed at reset so the first release after power-up is kept as well
         state_q.armed    <= 1'b1;
      // Clock enable low holds every flop, synchronisers and read answer included
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Arrival value store
   // All lanes written in the capture cycle; read data lag the index by one cycle
   lane_arrival_store uArrival (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .wrEn    (captureNow),
      .wrData  (laneArrivalIn),
      .rdIdx   (laneArrivalIdx),
      .rdData  (laneArrivalValues)
   );

   // ==========================================================
   // Outputs
   // Lane circuitry sees only the freeze; link reset goes to the digital receiver alone
   assign recoveryFreeze       = state_q.freeze;
   assign linkDigitalReset     = state_q.linkRst;
   assign extReferenceEnable   = state_q.ext_reference_ball;
   assign currentDoublerEnable = state_q.curDbl;
   assign regRdata             = state_q.rdata;
   assign regRvalid            = state_q.rvalid;

endmodule

// ===== test/serdes_regs_properties.sv
// Checker for the serial-receive register bank: port timing and control write-through.
// Assumes it is bound onto serdes_status_jesd_reset_regs and sees only its ports.
`timescale 1ns/1ns
module serdes_regs_properties (
   input  wire logic                                   sys_clk,
   input  wire logic                                   rst,
   input  wire logic                                   ce,
   input  wire logic                                   regWrite,
   input  wire logic                                   regRead,
   input  wire logic [serdes_regs_pkg::ADDR_W-1:0]     regAddr,
   input  wire logic [serdes_regs_pkg::DATA_W-1:0]     regWdata,
   input  wire logic [serdes_regs_pkg::DATA_W-1:0]     regRdata,
   input  wire logic                                   regRvalid,
   input  wire logic                                   linkDigitalReset,
   input  wire logic                                   extReferenceEnable,
   input  wire logic                                   currentDoublerEnable,
   input  wire logic                                   recoveryFreeze
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Read answer
   read_answer_a: assert property (ce && regRead |=> regRvalid)
      else $error("read not answered next cycle");
   idle_quiet_a: assert property (
      ce && !regRead |=> !regRvalid && regRdata == 8'h00)
      else $error("answer without read");
   unmapped_zero_a: assert property (
      ce && regRead && regAddr == 12'h100 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (
      ce && regRead && regAddr == 12'h2B0 |=> regRdata[7:1] == 7'h00)
      else $error("reserved bits not zero");
   // ==========================================================
   // Control outputs follow writes of bit 0
   link_reset_wr_a: assert property (
      ce && regWrite && regAddr == 12'h253
      |=> {7'h00, linkDigitalReset} == ($past(regWdata) & 8'h01))
      else $error("link reset not written");
   link_reset_hold_a: assert property (
      ce && !(regWrite && regAddr == 12'h253)
      |=> $stable(linkDigitalReset))
      else $error("link reset changed without write");
   ext_ref_wr_a: assert property (
      ce && regWrite && regAddr == 12'h2B0
      |=> {7'h00, extReferenceEnable} == ($past(regWdata) & 8'h01))
      else $error("reference select not written");
   doubler_wr_a: assert property (
      ce && regWrite && regAddr == 12'h2B1
      |=> {7'h00, currentDoublerEnable} == ($past(regWdata) & 8'h01))
      else $error("current doubler not written");
   freeze_wr_a: assert property (
      ce && regWrite && regAddr == 12'h238
      |=> {7'h00, recoveryFreeze} == ($past(regWdata) & 8'h01))
      else $error("freeze bit not written");
endmodule

// ===== test/serdes_status_jesd_reset_regs_tb.sv
// Self-checking bench for the serial-receive register bank, random plus corner cases.
// Assumes the package and the checker are compiled first; inputs driven at rising edges.
`timescale 1ns/1ns
module serdes_status_jesd_reset_regs_tb;
   localparam int           WATCHDOG_CYCLES = 2000;  // Several times the planned run
   logic                    sys_clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    ce = 1'b1;
   logic                    regWrite = 1'b0;
   logic                    regRead = 1'b0;
   logic                    elasticRelease = 1'b0;
   logic [11:0]             regAddr = 12'h000;
   logic [7:0]              regWdata = 8'h00;
   logic [7:0]              regRdata, laneArrivalValues, p;
   logic                    regRvalid, recoveryFreeze, linkDigitalReset;
   logic                    extReferenceEnable, currentDoublerEnable;
   logic [3:0]              laneSelect = 4'h0, laneArrivalIdx = 4'h0, ctl = 4'h0;
   logic [3:0]              pllLockedLive = 4'hF;
   logic [15:0][7:0]        lanePhase = '0, laneArrivalIn = '0, a;
   logic [7:0]              d;
   logic [11:0]             rwAddr [4] = '{12'h253, 12'h2B0, 12'h2B1, 12'h238};
   // Live lock, write data, expected read; third entry clears while the lock is still low
   logic [19:0]             lk [6] = '{20'hF0FF0, 20'h70078, 20'h70878, 20'hF00F8,
                                       20'hFF7F8, 20'hF08F0};
   int                      err_total = 0;
   int                      tests_run = 0;
   serdes_status_jesd_reset_regs dut_u (.sys_clk, .rst, .ce, .regWrite, .regRead, .regAddr,
      .regWdata, .regRdata, .regRvalid, .laneSelect, .lanePhase, .pllLockedLive,
      .elasticRelease, .laneArrivalIn, .laneArrivalIdx, .laneArrivalValues, .recoveryFreeze,
      .linkDigitalReset, .extReferenceEnable, .currentDoublerEnable);
   // ==========================================================
   // Tasks
   function automatic logic [7:0] gray(input logic [7:0] b);
      return b ^ (b >> 1);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] ad, input logic [7:0] wd);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr <= ad;
      regWdata <= wd;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] ad, input logic [7:0] exp);
      @(posedge sys_clk);
      regRead <= 1'b1;
      regAddr <= ad;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      chk({7'h00, regRvalid}, 8'h01);
      chk(regRdata, exp);
   endtask
   task automatic finish_test();
      $display("compares=%0d errors=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog, tests
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (WATCHDOG_CYCLES) @(posedge sys_clk);
      err_total++;
      finish_test();
   end
   initial begin
      void'($urandom(23));
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (rwAddr[i]) rdchk(rwAddr[i], 8'h00);
      rdchk(12'h100, 8'h00);
      // Bit 3 freeze, 2 doubler, 1 reference, 0 link reset, as rwAddr is ordered
      for (int n = 0; n < 16; n++) begin
         d = 8'($urandom());
         ctl[n % 4] = d[0];
         wr(rwAddr[n % 4], d);
         rdchk(rwAddr[n % 4], {7'h00, d[0]});
         p = {4'h0, recoveryFreeze, currentDoublerEnable, extReferenceEnable, linkDigitalReset};
         chk(p, {4'h0, ctl});
      end
      // Clock enable low: a write in that cycle must not land
      ce <= 1'b0;
      wr(12'h2B1, {7'h00, ~ctl[2]});
      ce <= 1'b1;
      rdchk(12'h2B1, {7'h00, ctl[2]});
      wr(12'h238, 8'h00);
      // Phase read follows the selected lane, Gray coded
      for (int n = 0; n < 4; n++) begin
         @(posedge sys_clk);
         laneSelect <= (n == 0) ? 4'hF : 4'($urandom());
         lanePhase <= {$urandom(), $urandom(), $urandom(), $urandom()};
         repeat (5) @(posedge sys_clk);
         rdchk(12'h239, gray(lanePhase[laneSelect]));
      end
      // Freeze before reading, then the held phase must not follow the lanes
      wr(12'h238, 8'h01);
      repeat (3) @(posedge sys_clk);
      p = gray(lanePhase[laneSelect]);
      lanePhase <= ~lanePhase;
      repeat (5) @(posedge sys_clk);
      rdchk(12'h239, p);
      // Lock live and sticky lost bits: live, write, expected read
      foreach (lk[i]) begin
         @(posedge sys_clk);
         pllLockedLive <= lk[i][19:16];
         repeat (4) @(posedge sys_clk);
         wr(12'h250, lk[i][15:8]);
         rdchk(12'h250, lk[i][7:0]);
      end
      // Arrival capture only at first release after link reset
      wr(12'h253, 8'h01);
      laneArrivalIn <= {$urandom(), $urandom(), $urandom(), $urandom()};
      elasticRelease <= 1'b1;
      @(posedge sys_clk);
      elasticRelease <= 1'b0;
      wr(12'h253, 8'h00);
      a = {$urandom(), $urandom(), $urandom(), $urandom()};
      laneArrivalIn <= a;
      elasticRelease <= 1'b1;
      @(posedge sys_clk);
      laneArrivalIn <= ~a;
      @(posedge sys_clk);
      elasticRelease <= 1'b0;
      for (int k = 0; k < 16; k++) begin
         laneArrivalIdx <= 4'(k);
         @(posedge sys_clk);
         #1;
         chk(laneArrivalValues, a[k]);
         @(posedge sys_clk);
      end
      finish_test();
   end
endmodule
bind serdes_status_jesd_reset_regs serdes_regs_properties chk_u (.sys_clk, .rst, .ce,
   .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regRvalid, .linkDigitalReset,
   .extReferenceEnable, .currentDoublerEnable, .recoveryFreeze);
